/* logic/sarcc_trigger_clock_control.sv */
// sar converter control: clock select, periodic trigger, sequencing, flags
//
// Functional notes
// - conversion clock is bus clock, bus clock halved, or local async clock
// - hw trigger on: a periodic counter overflow starts a conversion when idle
// - counter runs free on reference or slow clock; rate sets its period
// - periodic trigger keeps working in run, wait and stop3
// - exactly one analog pin enable register is provided
// - stop3 operation continues only while low-voltage stop enable is set
// - 12-bit successive approximation, right-justified as 12, 10 or 8 bits
// - single or continuous conversions; single returns to idle by itself
// - compare mode flags completion only for less-than or greater-or-equal
// - done flag set at completion and can raise an interrupt
// - channel select field picks one of up to 28 inputs
// - sample time short or long, speed versus power selectable
// - channel all ones powers converter off; temp and bandgap codes decoded
// - control write always aborts; it restarts unless channel is all ones, hw trigger is on or stop3 is held without enable
// - done flag read-only, cleared by control write or result low read
// - active flag set at start, cleared on single completion or abort
`default_nettype none
`include "sarcc_consts.svh"
module sarcc_trigger_clock_control #(
  parameter int RES_W = 12,
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire sarcc_pkg::sarcc_cfg_t cfg,
  input wire logic ctrlWrite,
  input wire logic resultLowRead,
  input wire logic [2:0] periodicRateSelect,
  input wire logic useExternalReference,
  input wire logic externalReferenceClock,
  input wire logic internalSlowClock,
  input wire logic localAsyncConvClock,
  input wire logic stopMode,
  input wire logic lowvoltDetectStopEnable,
  input wire logic [7:0] analogPinEnableOne,
  input wire logic cmpHigh,
  output logic [7:0] padAnalogEnable,
  output logic [4:0] sampleChannel,
  output logic sampleEnable,
  output logic converterPowered,
  output logic tempSensorSelect,
  output logic bandgapSelect,
  output logic [11:0] dacCode,
  output logic [11:0] result,
  output logic conversionDoneFlag,
  output logic conversionActiveFlag,
  output logic interruptRequest,
  output logic hwConversionTrigger
);
  if (RES_W != 12) begin : g_bad_res
    $error("only a 12-bit result width is supported");
  end
  if (CNT_W < 11) begin : g_bad_cnt
    $error("periodic counter too narrow for the rate select range");
  end

  // pin inputs: two flops each, a third flop only for the edge detect
  logic [2:0] pinRaw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic [2:0] pinRise;
  assign pinRaw = {internalSlowClock, externalReferenceClock,
                   localAsyncConvClock};
  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_sync
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        sync1_q[gi] <= 1'b0;
        sync2_q[gi] <= 1'b0;
        prev_q[gi] <= 1'b0;
      end else begin
        sync1_q[gi] <= pinRaw[gi];
        sync2_q[gi] <= sync1_q[gi];
        prev_q[gi] <= sync2_q[gi];
      end
    end
  end
  assign pinRise = sync2_q & ~prev_q;

  // conversion clock tick; the async clock must run below half the bus rate
  logic half_q;
  logic convTick;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) half_q <= 1'b0;
    else half_q <= ~half_q;
  end
  assign convTick = (cfg.clkSel == sarcc_pkg::SARCC_CLK_BUS) ? 1'b1 :
                    (cfg.clkSel == sarcc_pkg::SARCC_CLK_HALF) ? half_q :
                    pinRise[`SARCC_PIN_ASYNC];

  // periodic wakeup counter; rate zero stops it
  logic [CNT_W-1:0] pwc_q;
  logic [CNT_W-1:0] pwcLimit;
  logic pwcEdge;
  logic pwcOverflow;
  logic trig_q;
  assign pwcEdge = useExternalReference ? pinRise[`SARCC_PIN_EXTREF] :
                   pinRise[`SARCC_PIN_SLOW];
  assign pwcLimit = CNT_W'((`SARCC_CNT_ONE <<
                    (periodicRateSelect + `SARCC_RATE_BASE)) - `SARCC_CNT_ONE);
  assign pwcOverflow = pwcEdge && (periodicRateSelect != 3'h0) &&
                       (pwc_q == pwcLimit);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) pwc_q <= '0;
    else if (periodicRateSelect == 3'h0) pwc_q <= '0;
    else if (pwcOverflow) pwc_q <= '0;
    else if (pwcEdge) pwc_q <= pwc_q + CNT_W'(1);
  end
  // not gated by stop mode, so triggers survive run, wait and stop3
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) trig_q <= 1'b0;
    else trig_q <= pwcOverflow;
  end
  assign hwConversionTrigger = trig_q;

  // channel decode
  logic chanOff;
  assign chanOff = (cfg.chanSel == `SARCC_CH_DISABLED);
  assign converterPowered = !chanOff;
  assign tempSensorSelect = (cfg.chanSel == `SARCC_CH_TEMP);
  assign bandgapSelect = (cfg.chanSel == `SARCC_CH_BANDGAP);
  assign sampleChannel = cfg.chanSel;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) padAnalogEnable <= 8'h00;
    else padAnalogEnable <= analogPinEnableOne;
  end

  // sequencer
  sarcc_pkg::sarcc_state_t state_q;
  sarcc_pkg::sarcc_state_t state_d;
  logic [4:0] smpCnt_q;
  logic [3:0] bitIdx_q;
  logic slowPhase_q;
  logic [11:0] code_q;
  logic [11:0] codeStep;
  logic stopHold;
  logic abort;
  logic swStart;
  logic hwStart;
  logic startEv;
  logic stepEv;
  logic convDone;
  logic completeEv;
  logic cmpTrue;
  logic flagOk;
  logic [11:0] fmtResult;
  logic [4:0] smpLen;

  function automatic logic [11:0] formatResult(
    input logic [11:0] raw,
    input sarcc_pkg::sarcc_fmt_t fmt
  );
    if (fmt == sarcc_pkg::SARCC_FMT_12) formatResult = raw;
    else if (fmt == sarcc_pkg::SARCC_FMT_10) formatResult = {2'h0, raw[11:2]};
    else formatResult = {4'h0, raw[11:4]};
  endfunction

  assign stopHold = stopMode && !lowvoltDetectStopEnable;
  assign abort = ctrlWrite || stopHold || chanOff;
  assign swStart = ctrlWrite && !chanOff && !cfg.hwTrigEn && !stopHold;
  assign hwStart = cfg.hwTrigEn && trig_q && !chanOff && !stopHold &&
                   !ctrlWrite && (state_q == sarcc_pkg::SARCC_IDLE);
  assign startEv = swStart || hwStart;
  assign smpLen = cfg.longSample ? `SARCC_SAMPLE_LONG :
                  `SARCC_SAMPLE_SHORT;
  // low power takes two conversion clocks per bit
  assign stepEv = convTick && (!cfg.lowPower || slowPhase_q);
  assign convDone = (state_q == sarcc_pkg::SARCC_CONVERT) && stepEv &&
                    (bitIdx_q == 4'h0);
  assign completeEv = convDone && !abort;
  assign codeStep = cmpHigh ? code_q :
                    (code_q & ~(`SARCC_BIT_ONE << bitIdx_q));
  assign fmtResult = formatResult(codeStep, cfg.fmt);
  assign cmpTrue = cfg.cmpGreaterEq ? (fmtResult >= cfg.cmpValue) :
                   (fmtResult < cfg.cmpValue);
  assign flagOk = !cfg.cmpEn || cmpTrue;

  always_comb begin
    state_d = state_q;
    case (state_q)
      sarcc_pkg::SARCC_IDLE: begin
        if (hwStart) state_d = sarcc_pkg::SARCC_SAMPLE;
      end
      sarcc_pkg::SARCC_SAMPLE: begin
        if (convTick && smpCnt_q == 5'h00) state_d = sarcc_pkg::SARCC_CONVERT;
      end
      sarcc_pkg::SARCC_CONVERT: begin
        if (convDone) begin
          state_d = cfg.contEn ? sarcc_pkg::SARCC_SAMPLE :
                    sarcc_pkg::SARCC_IDLE;
        end
      end
      default: state_d = sarcc_pkg::SARCC_IDLE;
    endcase
    if (abort) state_d = sarcc_pkg::SARCC_IDLE;
    if (swStart) state_d = sarcc_pkg::SARCC_SAMPLE;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) state_q <= sarcc_pkg::SARCC_IDLE;
    else state_q <= state_d;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      smpCnt_q <= 5'h00;
      bitIdx_q <= 4'h0;
      slowPhase_q <= 1'b0;
      code_q <= 12'h000;
    end else if (state_d == sarcc_pkg::SARCC_SAMPLE &&
                 state_q != sarcc_pkg::SARCC_SAMPLE || startEv) begin
      smpCnt_q <= smpLen;
      slowPhase_q <= 1'b0;
    end else if (state_q == sarcc_pkg::SARCC_SAMPLE && convTick) begin
      smpCnt_q <= smpCnt_q - 5'h01;
      bitIdx_q <= `SARCC_MSB_INDEX;
      code_q <= `SARCC_CODE_MID;
    end else if (state_q == sarcc_pkg::SARCC_CONVERT && convTick) begin
      slowPhase_q <= ~slowPhase_q;
      if (stepEv && bitIdx_q != 4'h0) begin
        code_q <= codeStep | (`SARCC_BIT_ONE << (bitIdx_q - 4'h1));
        bitIdx_q <= bitIdx_q - 4'h1;
      end
    end
  end
  assign sampleEnable = (state_q == sarcc_pkg::SARCC_SAMPLE);
  assign dacCode = code_q;
  assign conversionActiveFlag = (state_q != sarcc_pkg::SARCC_IDLE);

  // flag: a completion in the clearing cycle wins
  logic done_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
      result <= 12'h000;
    end else begin
      if (completeEv && flagOk) begin
        done_q <= 1'b1;
        result <= fmtResult;
      end else if (ctrlWrite || resultLowRead) begin
        done_q <= 1'b0;
      end
    end
  end
  assign conversionDoneFlag = done_q;
  assign interruptRequest = done_q && cfg.intEn;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  start_sets_active_a: assert property (
    startEv |=> conversionActiveFlag)
    else $error("start did not set active");
  write_clears_flag_a: assert property (
    (ctrlWrite || resultLowRead) && !completeEv |=> !conversionDoneFlag)
    else $error("done flag not cleared");
  done_sets_flag_a: assert property (
    completeEv && flagOk |=> conversionDoneFlag && result == $past(fmtResult))
    else $error("completion did not set flag");
  irq_from_flag_a: assert property (
    $rose(conversionDoneFlag) && cfg.intEn |-> interruptRequest)
    else $error("interrupt missing");
  single_to_idle_a: assert property (
    completeEv && !cfg.contEn && !startEv |=> !conversionActiveFlag)
    else $error("single conversion did not return to idle");
  disabled_stays_off_a: assert property (
    ctrlWrite && chanOff ##1 chanOff |=> !conversionActiveFlag)
    else $error("conversion ran with channel disabled");
  hw_trig_start_a: assert property (hwStart |=> sampleEnable)
    else $error("hardware trigger did not start");
  cmp_false_keeps_a: assert property (
    completeEv && !flagOk && !ctrlWrite && !resultLowRead
    |=> $stable(conversionDoneFlag) && $stable(result))
    else $error("failed compare changed flag");
  stop_halts_a: assert property (stopHold |=> !conversionActiveFlag)
    else $error("conversion ran in stop without enable");
  logic [3:0] convCnt_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) convCnt_q <= 4'h0;
    else if (state_q != sarcc_pkg::SARCC_CONVERT) convCnt_q <= 4'h0;
    else convCnt_q <= convCnt_q + 4'h1;
  end
  convert_len_a: assert property (
    state_q == sarcc_pkg::SARCC_CONVERT && convCnt_q == `SARCC_MSB_INDEX &&
    cfg.clkSel == sarcc_pkg::SARCC_CLK_BUS && !cfg.lowPower |-> convDone)
    else $error("bus clock conversion not 12 cycles");

  single_done_c: cover property (swStart ##[1:60] completeEv);
  hw_done_c: cover property (hwStart ##[1:60] completeEv);
  cont_again_c: cover property (completeEv && cfg.contEn ##[1:60] completeEv);
  cmp_reject_c: cover property (completeEv && !flagOk);
endmodule
`default_nettype wire

/* logic/sarcc_consts.svh */
// named constants for the converter trigger and clock control block
`ifndef SARCC_CONSTS_SVH
`define SARCC_CONSTS_SVH
`define SARCC_CH_DISABLED 5'h1f
`define SARCC_CH_TEMP 5'h1a
`define SARCC_CH_BANDGAP 5'h1b
`define SARCC_SAMPLE_SHORT 5'h03
`define SARCC_SAMPLE_LONG 5'h17
`define SARCC_MSB_INDEX 4'hb
`define SARCC_CODE_MID 12'h800
`define SARCC_BIT_ONE 12'h001
`define SARCC_RATE_BASE 4'h3
`define SARCC_CNT_ONE 16'h0001
`define SARCC_PIN_ASYNC 0
`define SARCC_PIN_EXTREF 1
`define SARCC_PIN_SLOW 2
`endif

/* logic/sarcc_pkg.sv */
// types shared by the converter trigger and clock control block
`default_nettype none
package sarcc_pkg;
  typedef enum logic [1:0] {
    SARCC_CLK_BUS = 2'b00,
    SARCC_CLK_HALF = 2'b01,
    SARCC_CLK_ASYNC = 2'b10
  } sarcc_clk_t;
  typedef enum logic [1:0] {
    SARCC_FMT_8 = 2'b00,
    SARCC_FMT_12 = 2'b01,
    SARCC_FMT_10 = 2'b10
  } sarcc_fmt_t;
  typedef enum logic [1:0] {
    SARCC_IDLE = 2'b00,
    SARCC_SAMPLE = 2'b01,
    SARCC_CONVERT = 2'b10
  } sarcc_state_t;
  typedef struct packed {
    sarcc_clk_t clkSel;
    sarcc_fmt_t fmt;
    logic contEn;
    logic intEn;
    logic hwTrigEn;
    logic cmpEn;
    logic cmpGreaterEq;
    logic longSample;
    logic lowPower;
    logic [4:0] chanSel;
    logic [11:0] cmpValue;
  } sarcc_cfg_t;
endpackage
`default_nettype wire

/* test/sarcc_analog_model.sv */
// analog input and slow trigger clock model for the converter bench
`default_nettype none
module sarcc_analog_model (
  input wire logic clock,
  input wire logic [11:0] level,
  input wire logic [11:0] dacCode,
  input wire logic converterPowered,
  output logic cmpHigh,
  output logic slowClock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] divQ = 2'h0;
  // an unpowered input gives a toggling level, never a steady guess
  assign cmpHigh = converterPowered ? (level >= dacCode) : divQ[0];
  // slow source kept far below bus rate so the synchroniser sees each edge
  always @(posedge clock) begin
    divQ <= divQ + 2'h1;
  end
  assign slowClock = divQ[1];
endmodule
`default_nettype wire

/* test/sarcc_trigger_clock_control_tb.sv */
// self-checking bench for the converter trigger and clock control block
`default_nettype none
`include "sarcc_consts.svh"
module sarcc_trigger_clock_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, nrst = 1'b0, asyncClk = 1'b0, slowClk, cmpHigh;
  logic ctrlWrite = 1'b0, rdLow = 1'b0, stopMode = 1'b0, lvStop = 1'b0;
  logic useExt = 1'b0;
  logic [2:0] rateSel = 3'h0;
  logic [7:0] pinEn = 8'h00, padEn;
  logic [11:0] level = 12'h000, dacCode, result;
  logic [4:0] sampleChannel;
  logic sampleEnable, powered, tempSel, bgSel, done, active, irq, hwTrig;
  sarcc_pkg::sarcc_cfg_t cfg = '0;
  int fails = 0, compares = 0, cycles = 0;
  sarcc_trigger_clock_control u_dut (.clock(clock), .nrst(nrst), .cfg(cfg),
    .ctrlWrite(ctrlWrite), .resultLowRead(rdLow),
    .periodicRateSelect(rateSel), .useExternalReference(useExt),
    .externalReferenceClock(asyncClk), .internalSlowClock(slowClk),
    .localAsyncConvClock(asyncClk), .stopMode(stopMode),
    .lowvoltDetectStopEnable(lvStop), .analogPinEnableOne(pinEn),
    .cmpHigh(cmpHigh), .padAnalogEnable(padEn),
    .sampleChannel(sampleChannel), .sampleEnable(sampleEnable),
    .converterPowered(powered), .tempSensorSelect(tempSel),
    .bandgapSelect(bgSel), .dacCode(dacCode), .result(result),
    .conversionDoneFlag(done), .conversionActiveFlag(active),
    .interruptRequest(irq), .hwConversionTrigger(hwTrig));
  sarcc_analog_model u_model (.clock(clock), .level(level),
    .dacCode(dacCode), .converterPowered(powered), .cmpHigh(cmpHigh),
    .slowClock(slowClk));
  initial begin
    forever #2.5 clock = ~clock;
  end
  // async conversion clock about a tenth of bus rate, unrelated in phase;
  // it doubles as the external reference for the periodic counter
  initial begin
    #1.3;
    forever #23.5 asyncClk = ~asyncClk;
  end
  task automatic wrap_up();
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr();
    @(negedge clock);
    ctrlWrite = 1'b1;
    @(negedge clock);
    ctrlWrite = 1'b0;
  endtask
  task automatic rd();
    @(negedge clock);
    rdLow = 1'b1;
    @(negedge clock);
    rdLow = 1'b0;
  endtask
  task automatic wait_done(input int lim, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(negedge clock);
      seen = (done === 1'b1);
    end
  endtask
  task automatic wait_trig(input int lim, output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (hwTrig !== 1'b1 && n < lim);
  endtask
  task automatic setup(input logic [4:0] ch, input logic [11:0] lv);
    cfg = '0;
    cfg.fmt = sarcc_pkg::SARCC_FMT_12;
    cfg.chanSel = ch;
    level = lv;
  endtask
  task automatic t_single();
    logic s;
    setup(5'h03, 12'h5a3);
    cfg.intEn = 1'b1;
    pinEn = 8'h5a;
    wr();
    cyc(1);
    chk(active, 1'b1);
    chk(sampleEnable, 1'b1);
    chk(dacCode, `SARCC_CODE_MID);
    chk(sampleChannel, 5'h03);
    chk(padEn, 8'h5a);
    wait_done(100, s);
    chk(s, 1'b1);
    chk(result, 12'h5a3);
    chk(irq, 1'b1);
    chk(active, 1'b0);
    rd();
    chk(done, 1'b0);
    $display("single conversion done");
  endtask
  task automatic t_fmt();
    logic s;
    for (int k = 0; k < 2; k++) begin
      setup(5'h05, 12'hb6d);
      cfg.fmt = k == 0 ? sarcc_pkg::SARCC_FMT_10 : sarcc_pkg::SARCC_FMT_8;
      wr();
      wait_done(100, s);
      chk(result, k == 0 ? 12'h2db : 12'h0b6);
    end
    $display("formats done");
  endtask
  task automatic t_cmp();
    logic s;
    for (int k = 0; k < 2; k++) begin
      setup(5'h02, 12'h400);
      cfg.cmpEn = 1'b1;
      cfg.cmpValue = 12'h300;
      cfg.cmpGreaterEq = k[0];
      wr();
      wait_done(60, s);
      chk(s, k[0]);
    end
    $display("compare done");
  endtask
  task automatic t_abort();
    logic s;
    setup(5'h03, 12'h123);
    wr();
    cyc(10);
    wr();
    wait_done(12, s);
    chk(s, 1'b0);
    wait_done(40, s);
    chk(s, 1'b1);
    cfg.chanSel = 5'h1a;
    cyc(1);
    chk(tempSel, 1'b1);
    cfg.chanSel = 5'h1b;
    wr();
    cfg.chanSel = `SARCC_CH_DISABLED;
    cyc(2);
    chk(active, 1'b0);
    chk(powered, 1'b0);
    wr();
    cyc(2);
    chk(active, 1'b0);
    $display("abort done");
  endtask
  task automatic t_hw();
    logic s;
    int n;
    setup(5'h04, 12'h7ff);
    cfg.hwTrigEn = 1'b1;
    rateSel = 3'h1;
    wr();
    chk(active, 1'b0);
    wait_trig(300, n);
    wait_trig(300, n);
    chk(n, 64);
    rd();
    chk(active, 1'b1);
    wait_done(100, s);
    chk(s, 1'b1);
    chk(result, 12'h7ff);
    rd();
    stopMode = 1'b1;
    lvStop = 1'b1;
    wait_trig(300, n);
    wait_done(100, s);
    chk(s, 1'b1);
    lvStop = 1'b0;
    wait_trig(300, n);
    cyc(2);
    chk(active, 1'b0);
    stopMode = 1'b0;
    useExt = 1'b1;
    wait_trig(300, n);
    wait_trig(300, n);
    chk(n >= 149 && n <= 152, 1'b1);
    useExt = 1'b0;
    rateSel = 3'h0;
    $display("hardware trigger done");
  endtask
  task automatic t_clk();
    logic s;
    for (int k = 0; k < 2; k++) begin
      setup(5'h06, 12'h3c5);
      cfg.clkSel = k == 0 ? sarcc_pkg::SARCC_CLK_HALF
                          : sarcc_pkg::SARCC_CLK_ASYNC;
      cfg.longSample = k[0];
      cfg.lowPower = k[0];
      wr();
      wait_done(900, s);
      chk(s, 1'b1);
      chk(result, 12'h3c5);
    end
    $display("clock sources done");
  endtask
  // the model's async clock is faster than a real sensor read wants;
  // only the long sample and the channel order are exercised here
  task automatic t_temp();
    logic s;
    setup(`SARCC_CH_BANDGAP, 12'h5d1);
    cfg.clkSel = sarcc_pkg::SARCC_CLK_ASYNC;
    cfg.longSample = 1'b1;
    wr();
    chk(bgSel, 1'b1);
    wait_done(900, s);
    chk(s, 1'b1);
    chk(result, 12'h5d1);
    cfg.chanSel = `SARCC_CH_TEMP;
    level = 12'h2e4;
    wr();
    chk(tempSel, 1'b1);
    wait_done(900, s);
    chk(s, 1'b1);
    chk(result, 12'h2e4);
    $display("temperature sequence done");
  endtask
  task automatic t_cont();
    logic s;
    setup(5'h07, 12'h0a5);
    cfg.contEn = 1'b1;
    wr();
    wait_done(100, s);
    rd();
    wait_done(100, s);
    chk(s, 1'b1);
    chk(result, 12'h0a5);
    cfg.chanSel = `SARCC_CH_DISABLED;
    cyc(2);
    chk(active, 1'b0);
    $display("continuous done");
  endtask
  initial begin
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    t_single();
    t_fmt();
    t_cmp();
    t_abort();
    t_hw();
    t_clk();
    t_temp();
    t_cont();
    wrap_up();
  end
endmodule
`default_nettype wire
